// [core/cpu_pc_and_core_registers.v]
/*
  Program counter with bank flag, stacking sequencer, nine-bit data RAM
  front end, working registers, stack pointer and status word.
  Assumes a decoder outside issues one command at a time, waits for
  busy_out low, and supplies flag results from its ALU.
*/
`timescale 1ns/100ps
`include "cpu_core_defines.vh"
module cpu_pc_and_core_registers
#(
  parameter RAM_ADDR_WIDTH = 10
)
(
  input wire clk_in,
  input wire rst_n_in,
  input wire start_high_option_in,
  input wire pc_step_in,
  input wire [2:0] pc_op_in,
  input wire [2:0] instr_bytes_in,
  input wire [16:0] jump_target_in,
  input wire [11:0] rel12_in,
  input wire [7:0] rel8_in,
  input wire int_accept_in,
  input wire [3:0] int_vector_in,
  input wire data_wr_in,
  input wire data_rd_in,
  input wire [15:0] data_addr_in,
  input wire [7:0] data_wr_in_byte_in,
  input wire flag_wr_in,
  input wire [7:0] flag_mask_in,
  input wire [7:0] flag_value_in,
  input wire [5:0] indirect_sel_in,
  output reg [16:0] program_counter_out,
  output reg bank_flag_out,
  output reg [7:0] data_rd_out,
  output reg data_rd_valid_out,
  output reg [7:0] primary_working_register_out,
  output reg [7:0] second_working_out,
  output reg [7:0] third_working_out,
  output reg [7:0] status_out,
  output reg [15:0] stack_pointer_out,
  output reg busy_out,
  output reg option_area_out
);
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_PUSH_LOW = 3'h1;
  localparam ST_PUSH_HIGH = 3'h2;
  localparam ST_POP_HIGH = 3'h3;
  localparam ST_POP_WAIT = 3'h4;
  localparam ST_POP_LOW = 3'h5;
  localparam ST_POP_DONE = 3'h6;
  localparam ST_READ = 3'h7;

  reg [2:0] state;
  reg [16:0] pc;
  reg bank;
  reg [7:0] primary;
  reg [7:0] second;
  reg [7:0] third;
  reg [7:0] status_store;
  reg [15:0] sp;
  reg [16:0] saved_target;
  reg [8:0] popped_high;
  reg read_is_ram;
  reg ram_we;
  reg [RAM_ADDR_WIDTH-1:0] ram_addr;
  reg [8:0] ram_wdata;
  wire [8:0] ram_rdata;
  wire parity_now;
  wire [7:0] status_view;
  wire [16:0] vector_addr;
  reg [16:0] next_pc;
  reg next_push;
  reg start_loaded;
  reg int_pending_bank;

  // ----------------------------------------------------------------
  // Address decode and sign-extension helpers
  // ----------------------------------------------------------------
  function is_ram;
    input [15:0] a;
    begin
      is_ram = (a <= `ADDR_RAM_TOP);
    end
  endfunction

  function [16:0] sext12;
    input [11:0] v;
    begin
      sext12 = {{5{v[11]}}, v};
    end
  endfunction

  assign parity_now = ^primary;
  assign status_view = {status_store[7:1], parity_now};
  assign vector_addr = `VECTOR_BASE +
    {10'h000, int_vector_in, 3'h0};

  // ----------------------------------------------------------------
  // Next program counter
  // ----------------------------------------------------------------
  always @*
  begin
    next_pc = pc + {14'h0000, instr_bytes_in};
    next_push = 1'b0;
    case (pc_op_in)
      `PC_OP_NEXT: next_pc = pc + {14'h0000, instr_bytes_in};
      `PC_OP_JUMP: next_pc = jump_target_in;
      `PC_OP_REL12: next_pc = pc + 17'h00002 + sext12(rel12_in);
      `PC_OP_REL8: next_pc = pc + {14'h0000, instr_bytes_in} +
        {{9{rel8_in[7]}}, rel8_in};
      `PC_OP_INDEXED:
      begin
        next_pc = pc + 17'h00001 + {9'h000, primary};
        next_push = 1'b1;
      end
      `PC_OP_CALL_ABS:
      begin
        next_pc = jump_target_in;
        next_push = 1'b1;
      end
      `PC_OP_CALL_REL:
      begin
        next_pc = pc + 17'h00002 + sext12(rel12_in);
        next_push = 1'b1;
      end
      default: next_pc = pc;
    endcase
  end

  cpu_ram9 #(.ADDR_WIDTH(RAM_ADDR_WIDTH)) u_ram
  (
    .clk_in(clk_in),
    .wr_en_in(ram_we),
    .addr_in(ram_addr),
    .wr_data_in(ram_wdata),
    .rd_data_out(ram_rdata)
  );

  // ----------------------------------------------------------------
  // RAM port steering
  // ----------------------------------------------------------------
  always @*
  begin
    ram_we = 1'b0;
    ram_addr = data_addr_in[RAM_ADDR_WIDTH-1:0];
    ram_wdata = {status_store[`BIT_NINTH_RAM], data_wr_in_byte_in};
    case (state)
      ST_IDLE:
      begin
        if (int_accept_in || (pc_step_in && next_push))
        begin
          ram_we = 1'b1;
          ram_addr = sp[RAM_ADDR_WIDTH-1:0] + 1'b1;
          ram_wdata = {bank, pc[7:0]};
        end
        else if (pc_step_in && pc_op_in == `PC_OP_RETURN)
        begin
          ram_addr = sp[RAM_ADDR_WIDTH-1:0];
        end
        else if (data_wr_in && is_ram(data_addr_in))
        begin
          ram_we = 1'b1;
        end
        else if (pc_step_in && data_rd_in == 1'b0)
        begin
          ram_addr = {{(RAM_ADDR_WIDTH-7){1'b0}},
            indirect_sel_in, 1'b0};
        end
      end
      ST_PUSH_LOW:
      begin
        ram_we = 1'b1;
        ram_addr = sp[RAM_ADDR_WIDTH-1:0] + 1'b1;
        ram_wdata = pc[16:8];
      end
      ST_POP_HIGH, ST_POP_WAIT, ST_POP_LOW:
      begin
        ram_addr = sp[RAM_ADDR_WIDTH-1:0];
      end
      default:
      begin
        ram_we = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers and sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= ST_IDLE;
      pc <= `PC_START_LOW;
      bank <= 1'b0;
      primary <= `RESET_BYTE;
      second <= `RESET_BYTE;
      third <= `RESET_BYTE;
      status_store <= `RESET_BYTE;
      sp <= `RESET_SP;
      saved_target <= `PC_START_LOW;
      popped_high <= 9'h000;
      read_is_ram <= 1'b0;
      data_rd_out <= `RESET_BYTE;
      data_rd_valid_out <= 1'b0;
    end
    else
    begin
      data_rd_valid_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (int_accept_in)
          begin
            saved_target <= vector_addr;
            sp <= sp + 16'h0001;
            state <= ST_PUSH_LOW;
          end
          else if (pc_step_in && next_push)
          begin
            saved_target <= next_pc;
            sp <= sp + 16'h0001;
            state <= ST_PUSH_LOW;
          end
          else if (pc_step_in && pc_op_in == `PC_OP_RETURN)
          begin
            state <= ST_POP_HIGH;
          end
          else if (pc_step_in)
          begin
            pc <= next_pc;
          end
          else if (data_rd_in)
          begin
            read_is_ram <= is_ram(data_addr_in);
            state <= ST_READ;
            case (data_addr_in)
              `ADDR_PRIMARY: data_rd_out <= primary;
              `ADDR_SECOND: data_rd_out <= second;
              `ADDR_THIRD: data_rd_out <= third;
              `ADDR_STATUS: data_rd_out <= status_view;
              `ADDR_SP_LOW: data_rd_out <= sp[7:0];
              `ADDR_SP_HIGH: data_rd_out <= sp[15:8];
              default: data_rd_out <= 8'hFF;
            endcase
          end
          else if (data_wr_in)
          begin
            case (data_addr_in)
              `ADDR_PRIMARY: primary <= data_wr_in_byte_in;
              `ADDR_SECOND: second <= data_wr_in_byte_in;
              `ADDR_THIRD: third <= data_wr_in_byte_in;
              `ADDR_STATUS: status_store <= data_wr_in_byte_in;
              `ADDR_SP_LOW: sp[7:0] <= data_wr_in_byte_in;
              `ADDR_SP_HIGH: sp[15:8] <= data_wr_in_byte_in;
              default: sp <= sp;
            endcase
          end
          if (flag_wr_in && !data_wr_in)
          begin
            status_store <= (status_store & ~flag_mask_in) |
              (flag_value_in & flag_mask_in);
          end
        end
        ST_PUSH_LOW:
        begin
          sp <= sp + 16'h0001;
          state <= ST_PUSH_HIGH;
        end
        ST_PUSH_HIGH:
        begin
          pc <= saved_target;
          if (int_pending_bank)
          begin
            bank <= 1'b0;
          end
          state <= ST_IDLE;
        end
        ST_POP_HIGH:
        begin
          sp <= sp - 16'h0001;
          state <= ST_POP_WAIT;
        end
        ST_POP_WAIT:
        begin
          popped_high <= ram_rdata;
          state <= ST_POP_LOW;
        end
        ST_POP_LOW:
        begin
          sp <= sp - 16'h0001;
          state <= ST_POP_DONE;
        end
        ST_POP_DONE:
        begin
          pc <= {popped_high, ram_rdata[7:0]};
          bank <= ram_rdata[8];
          state <= ST_IDLE;
        end
        ST_READ:
        begin
          if (read_is_ram)
          begin
            data_rd_out <= ram_rdata[7:0];
            status_store[`BIT_NINTH_RAM] <= ram_rdata[8];
          end
          data_rd_valid_out <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (!start_loaded)
      begin
        pc <= start_high_option_in ?
          `PC_START_HIGH : `PC_START_LOW;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset start address and interrupt bank clear
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      start_loaded <= 1'b0;
      int_pending_bank <= 1'b0;
    end
    else
    begin
      start_loaded <= 1'b1;
      if (state == ST_IDLE)
      begin
        int_pending_bank <= int_accept_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      program_counter_out <= `PC_START_LOW;
      bank_flag_out <= 1'b0;
      primary_working_register_out <= `RESET_BYTE;
      second_working_out <= `RESET_BYTE;
      third_working_out <= `RESET_BYTE;
      status_out <= `RESET_BYTE;
      stack_pointer_out <= `RESET_SP;
      busy_out <= 1'b0;
      option_area_out <= 1'b0;
    end
    else
    begin
      program_counter_out <= start_loaded ? pc :
        (start_high_option_in ? `PC_START_HIGH : `PC_START_LOW);
      bank_flag_out <= (int_pending_bank && state == ST_PUSH_HIGH) ?
        1'b0 : bank;
      primary_working_register_out <= primary;
      second_working_out <= second;
      third_working_out <= third;
      status_out <= status_view;
      stack_pointer_out <= sp;
      busy_out <= (state != ST_IDLE) || int_accept_in ||
        (pc_step_in && (next_push || pc_op_in == `PC_OP_RETURN)) ||
        data_rd_in;
      option_area_out <= !bank && pc >= `OPTION_AREA_BASE;
    end
  end
endmodule // cpu_pc_and_core_registers

// [core/cpu_core_defines.vh]
/*
  Constants for the program-flow and core-register block of an 8-bit CPU:
  data addresses, status bit positions, reset and vector addresses.
  Assumes it is included by bare name from the design files.
*/
// Overview of operation
// - 17-bit program counter plus separate bank flag.
// - Reset clears bank, loads start address option.
// - Interrupt clears bank, loads one of ten vectors.
// - Jump, relative branch, call and indexed call targets.
// - Taken conditional branch adds length plus displacement.
// - Ordinary instructions advance by byte count.
// - Return pops high bits, low bits, bank.
// - Call pushes bank with low byte, then high.
// - Top 256 bytes of bank 0 reserved.
// - Data RAM nine bits, ninth via status bit 1.
// - Low 128 bytes form 64 indirect registers.
// - Primary working register at FE00, reset zero.
// - Second working register at FE01 for wide ops.
// - Third working register at FE02 signed offset.
// - Status word at FE06, cleared, fixed bit layout.
// - Carry flag from add, subtract, compare, rotate.
// - Half carry from bit 3 carry or borrow.
// - Status bits 5 and 4 are user storage.
// - Status bit 3 selects table read bank.
// - Range error flag on overflow or zero divide.
// - Parity bit shows odd count of accumulator ones.
// - Stack pointer at FE0A and FE0B, cleared.
`ifndef CPU_CORE_DEFINES_VH
`define CPU_CORE_DEFINES_VH
`define ADDR_PRIMARY 16'hFE00
`define ADDR_SECOND 16'hFE01
`define ADDR_THIRD 16'hFE02
`define ADDR_STATUS 16'hFE06
`define ADDR_SP_LOW 16'hFE0A
`define ADDR_SP_HIGH 16'hFE0B
`define ADDR_RAM_TOP 16'hFDFF
`define ADDR_INDIRECT_TOP 16'h007F
`define PC_START_LOW 17'h00000
`define PC_START_HIGH 17'h0FE00
`define VECTOR_BASE 17'h00003
`define VECTOR_STEP_SHIFT 3
`define VECTOR_COUNT 4'hA
`define OPTION_AREA_BASE 17'h1FF00
`define BIT_CARRY 7
`define BIT_HALF_CARRY 6
`define BIT_USER_5 5
`define BIT_USER_4 4
`define BIT_TABLE_BANK 3
`define BIT_RANGE_ERROR 2
`define BIT_NINTH_RAM 1
`define BIT_PARITY 0
`define RESET_BYTE 8'h00
`define RESET_SP 16'h0000
`define PC_OP_NEXT 3'h0
`define PC_OP_JUMP 3'h1
`define PC_OP_REL12 3'h2
`define PC_OP_REL8 3'h3
`define PC_OP_INDEXED 3'h4
`define PC_OP_CALL_ABS 3'h5
`define PC_OP_CALL_REL 3'h6
`define PC_OP_RETURN 3'h7
`endif

// [core/cpu_ram9.v]
/*
  Nine-bit wide data RAM with a registered read port.
  Assumes a single clock and one access per cycle from the core.
*/
`timescale 1ns/100ps
module cpu_ram9
#(
  parameter ADDR_WIDTH = 10
)
(
  input wire clk_in,
  input wire wr_en_in,
  input wire [ADDR_WIDTH-1:0] addr_in,
  input wire [8:0] wr_data_in,
  output reg [8:0] rd_data_out
);
  reg [8:0] mem [0:(1<<ADDR_WIDTH)-1];

  always @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem[addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[addr_in];
  end
endmodule // cpu_ram9

// [test/cpu_pc_asserts.sv]
/*
  Port-level assertions for the program-flow and core-register block.
  Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/100ps
module cpu_pc_asserts
(
  input wire clk_in,
  input wire rst_n_in,
  input wire pc_step_in,
  input wire [2:0] pc_op_in,
  input wire [2:0] instr_bytes_in,
  input wire [16:0] jump_target_in,
  input wire int_accept_in,
  input wire [3:0] int_vector_in,
  input wire data_rd_in,
  input wire [16:0] program_counter_out,
  input wire bank_flag_out,
  input wire data_rd_valid_out,
  input wire [7:0] primary_working_register_out,
  input wire [7:0] status_out,
  input wire [15:0] stack_pointer_out,
  input wire busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire go = pc_step_in && !busy_out;
  wire irq = int_accept_in && !busy_out;
  reg [16:0] want;
  reg [15:0] sp_q;
  always @(posedge clk_in)
  begin
    if (irq)
      want <= 17'h00003 + {10'h000, int_vector_in, 3'h0};
    else if (go)
      want <= jump_target_in;
    if (go || irq)
      sp_q <= stack_pointer_out;
  end
  property p_rd;
    data_rd_in && !busy_out |-> ##2 data_rd_valid_out;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_par;
    status_out[0] == ^primary_working_register_out;
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  property p_next;
    go && pc_op_in == 3'h0 |->
      ##2 program_counter_out ==
      $past(program_counter_out) + $past(instr_bytes_in, 2);
  endproperty
  a_next: assert property (p_next) else $error("step wrong");
  property p_jump;
    go && pc_op_in == 3'h1 |-> ##2 program_counter_out == want;
  endproperty
  a_jump: assert property (p_jump) else $error("jump wrong");
  property p_hold;
    go && pc_op_in != 3'h7 && !int_accept_in |=> $stable(bank_flag_out)[*4];
  endproperty
  a_hold: assert property (p_hold) else $error("bank moved");
  property p_ibank;
    irq |-> ##[1:4] !bank_flag_out;
  endproperty
  a_ibank: assert property (p_ibank) else $error("bank kept");
  property p_ipc;
    irq |-> ##4 program_counter_out == want;
  endproperty
  a_ipc: assert property (p_ipc) else $error("vector wrong");
  property p_cbusy;
    go && pc_op_in == 3'h5 |=> busy_out[*3] ##1 !busy_out;
  endproperty
  a_cbusy: assert property (p_cbusy) else $error("call busy");
  property p_csp;
    go && pc_op_in >= 3'h4 && pc_op_in <= 3'h6 |->
      ##4 stack_pointer_out == sp_q + 16'h0002;
  endproperty
  a_csp: assert property (p_csp) else $error("push wrong");
  property p_rsp;
    go && pc_op_in == 3'h7 |->
      ##6 !busy_out && stack_pointer_out == sp_q - 16'h0002;
  endproperty
  a_rsp: assert property (p_rsp) else $error("pop wrong");
  c_irq: cover property (irq);
  c_ret: cover property (go && pc_op_in == 3'h7);
  c_rd: cover property (data_rd_valid_out);
endmodule // cpu_pc_asserts

bind cpu_pc_and_core_registers cpu_pc_asserts cpu_pc_asserts_i
(
  .clk_in(clk_in), .rst_n_in(rst_n_in), .pc_step_in(pc_step_in),
  .pc_op_in(pc_op_in), .instr_bytes_in(instr_bytes_in),
  .jump_target_in(jump_target_in), .int_accept_in(int_accept_in),
  .int_vector_in(int_vector_in), .data_rd_in(data_rd_in),
  .program_counter_out(program_counter_out),
  .bank_flag_out(bank_flag_out), .data_rd_valid_out(data_rd_valid_out),
  .primary_working_register_out(primary_working_register_out),
  .status_out(status_out), .stack_pointer_out(stack_pointer_out),
  .busy_out(busy_out)
);

// [test/testbench.sv]
/*
  Self-checking bench for the program-flow and core-register block.
  Assumes the hand-over timing: answers settle within eight cycles.
*/
`timescale 1ns/100ps
module testbench;
  reg clk_in = 1'b0, rst_n_in = 1'b0, opt = 1'b1, step = 1'b0, irq = 1'b0;
  reg wr = 1'b0, rd = 1'b0, fw = 1'b0, bank = 1'b0;
  reg [2:0] op = 3'h0, nb = 3'h0;
  reg [16:0] tgt = 17'h00000, pc = 17'h00000, old, t;
  reg [11:0] r12 = 12'h000;
  reg [7:0] r8 = 8'h00, wd = 8'h00, fm = 8'h00, fv = 8'h00, acc = 8'h00;
  reg [7:0] st = 8'h00, d;
  reg [7:0] b = 8'h00, c = 8'h00;
  reg [3:0] vec = 4'h0;
  reg [15:0] addr = 16'h0000, sp = 16'h0000;
  wire [16:0] pc_o;
  wire [15:0] sp_o;
  wire [7:0] rd_o, a_o, st_o, b_o, c_o;
  wire bank_o, rv_o, busy_o, opt_o;
  integer fail_count = 0, total_checks = 0, i, r;
  reg [7:0] q[$];
  reg [15:0] ra[0:5] = '{16'hFE00, 16'hFE01, 16'hFE02, 16'hFE06,
    16'hFE0A, 16'hFE0B};
  cpu_pc_and_core_registers cpu_pc_and_core_registers_i
  (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .start_high_option_in(opt),
    .pc_step_in(step), .pc_op_in(op), .instr_bytes_in(nb),
    .jump_target_in(tgt), .rel12_in(r12), .rel8_in(r8),
    .int_accept_in(irq), .int_vector_in(vec), .data_wr_in(wr),
    .data_rd_in(rd), .data_addr_in(addr), .data_wr_in_byte_in(wd),
    .flag_wr_in(fw), .flag_mask_in(fm), .flag_value_in(fv),
    .indirect_sel_in(6'h00), .program_counter_out(pc_o),
    .bank_flag_out(bank_o), .data_rd_out(rd_o), .data_rd_valid_out(rv_o),
    .primary_working_register_out(a_o), .second_working_out(b_o),
    .third_working_out(c_o), .status_out(st_o), .stack_pointer_out(sp_o),
    .busy_out(busy_o), .option_area_out(opt_o)
  );
  initial
  begin
    forever #2 clk_in = ~clk_in;
  end
  task chk(input string n, input [16:0] e, input [16:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("BAD %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task end_sim;
    begin
      if (q.size() != 0)
        fail_count = fail_count + 1;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Request tasks
  // ----------------------------------------------------------------
  task fire(input integer k);
    integer n;
    begin
      n = 0;
      @(negedge clk_in);
      while (busy_o !== 1'b0 && n < 40)
      begin
        @(negedge clk_in);
        n = n + 1;
      end
      if (busy_o !== 1'b0)
        fail_count = fail_count + 1;
      @(posedge clk_in);
      {step, irq, wr, rd, fw} <= 5'h10 >> k;
      @(posedge clk_in);
      {step, irq, wr, rd, fw} <= 5'h00;
      repeat (8) @(negedge clk_in);
    end
  endtask
  task wreg(input [15:0] a, input [7:0] v);
    begin
      @(posedge clk_in);
      addr <= a;
      wd <= v;
      fire(2);
    end
  endtask
  task rreg(input [15:0] a, input [7:0] e);
    begin
      @(posedge clk_in);
      addr <= a;
      q.push_back(e);
      fire(3);
    end
  endtask
  task flags(input [7:0] m, input [7:0] v);
    begin
      @(posedge clk_in);
      fm <= m;
      fv <= v;
      fire(4);
      st = (st & ~m) | (v & m);
    end
  endtask
  task look;
    begin
      chk("pc", pc, pc_o);
      chk("bank", bank, bank_o);
      chk("sp", sp, sp_o);
      chk("status", {st[7:1], ^acc}, st_o);
      chk("option", pc >= 17'h1FF00 && !bank, opt_o);
      chk("primary", acc, a_o);
      chk("second", b, b_o);
      chk("third", c, c_o);
    end
  endtask
  task pcop(input [2:0] o, input [16:0] a);
    begin
      @(posedge clk_in);
      nb <= 3'h1 + $urandom % 3;
      r12 <= $urandom;
      r8 <= $urandom;
      op <= o;
      tgt <= a;
      fire(0);
      old = pc;
      case (o)
        3'h0: pc = pc + nb;
        3'h1, 3'h5, 3'h7: pc = a;
        3'h2, 3'h6: pc = pc + 17'h00002 + {{5{r12[11]}}, r12};
        3'h3: pc = pc + nb + {{9{r8[7]}}, r8};
        default: pc = pc + 17'h00001 + acc;
      endcase
      if (o == 3'h7)
        sp = sp - 16'h0002;
      else if (o >= 3'h4)
        sp = sp + 16'h0002;
      look;
    end
  endtask
  always @(negedge clk_in)
  begin
    if (rv_o === 1'b1)
      if (q.size() == 0)
        chk("read", 17'h00000, 17'h1FFFF);
      else
        chk("read", q.pop_front(), rd_o);
  end
  initial
  begin
    #80000;
    fail_count = fail_count + 1;
    end_sim;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    r = $urandom(18493);
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    chk("start", 17'h0FE00, pc_o);
    pc = 17'h0FE00;
    for (i = 0; i < 6; i = i + 1)
      rreg(ra[i], 8'h00);
    for (i = 0; i < 3; i = i + 1)
    begin
      d = $urandom;
      wreg(ra[i], d);
      rreg(ra[i], d);
      if (i == 0)
        acc = d;
      if (i == 1)
        b = d;
      if (i == 2)
        c = d;
    end
    rreg(16'hFE03, 8'hFF);
    wreg(16'hFE06, 8'hF4);
    st = 8'hF4;
    rreg(16'hFE06, {st[7:1], ^acc});
    flags(8'h38, 8'h28);
    look;
    $display("register test done");
    wreg(16'hFE0A, 8'h40);
    wreg(16'hFE0B, 8'h00);
    sp = 16'h0040;
    t = $urandom;
    flags(8'h02, {6'h00, t[16], 1'b0});
    wreg(16'h0040, t[15:8]);
    flags(8'h02, 8'h02);
    wreg(16'h003F, t[7:0]);
    flags(8'h02, 8'h00);
    rreg(16'h003F, t[7:0]);
    st[1] = 1'b1;
    chk("ninth", 1'b1, st_o[1]);
    bank = 1'b1;
    pcop(3'h7, t);
    for (i = 0; i < 7; i = i + 1)
      pcop(i[2:0], $urandom);
    pcop(3'h5, $urandom);
    rreg(sp - 16'h0001, old[7:0]);
    st[1] = bank;
    rreg(sp, old[15:8]);
    st[1] = old[16];
    pcop(3'h7, old);
    $display("flow test done");
    for (i = 0; i < 10; i = i + 1)
    begin
      @(posedge clk_in);
      vec <= i[3:0];
      fire(1);
      pc = 17'h00003 + 17'h00008 * i;
      bank = 1'b0;
      sp = sp + 16'h0002;
      look;
    end
    pcop(3'h1, 17'h1FF00);
    @(posedge clk_in);
    op <= 3'h0;
    nb <= 3'h2;
    step <= 1'b1;
    @(posedge clk_in);
    @(posedge clk_in);
    step <= 1'b0;
    repeat (6) @(negedge clk_in);
    pc = pc + 17'h00004;
    look;
    $display("vector test done");
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    opt <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    chk("start", 17'h00000, pc_o);
    {pc, sp, acc, st, b, c} = 0;
    rreg(16'hFE00, 8'h00);
    look;
    $display("reset test done");
    end_sim;
  end
endmodule // testbench
